//--- design/etc_regs.svh
// Purpose: register offsets, field positions, reset values and counts of the tonality classifier
// Assumes: byte addresses on a 32-bit classic Wishbone port, one aligned word per register
// Notes: thresholds compare against the scaled deviation squared, unsigned Q16.16 in dB^2
`ifndef ETC_REGS_SVH
`define ETC_REGS_SVH

// register byte offsets
`define ETC_ADR_CTRL 8'h00
`define ETC_ADR_STATUS 8'h04
`define ETC_ADR_DEV 8'h08
`define ETC_ADR_THR1 8'h0c
`define ETC_ADR_THR2 8'h10
`define ETC_ADR_THR3 8'h14
`define ETC_ADR_THR4 8'h18
`define ETC_ADR_FRAMES 8'h1c

// control fields and reset value
`define ETC_CTRL_EN_BIT 0
`define ETC_CTRL_RST 1'b1

// status field positions
`define ETC_ST_CAT_LSB 0
`define ETC_ST_HOLD_LSB 4
`define ETC_ST_TONAL_LSB 8
`define ETC_ST_PLAIN_LSB 16

// frame counts
`define ETC_HIST_FRAMES 40
`define ETC_DEV_FRAMES 15
`define ETC_RUN_LIMIT 30
`define ETC_ERASE_FRAMES 3

// deviation scale p = 0.77, kept in hundredths
`define ETC_DEV_SCALE_X100 77

// thresholds, element 0 is threshold 1 and sits last in each packed list
`define ETC_THR_INIT {32'h0004_0000, 32'h0002_0000, 32'h0001_0000, 32'h0000_8000}
`define ETC_THR_MIN {32'h0002_0000, 32'h0001_0000, 32'h0000_8000, 32'h0000_4000}
`define ETC_THR_MAX {32'h0008_0000, 32'h0004_0000, 32'h0002_0000, 32'h0001_0000}
`define ETC_THR_STEP 32'h0000_1000

// category tuning for the noise reducer
`define ETC_F_STOP_HZ 13'h1900
`define ETC_F_510_HZ 13'h01fe
`define ETC_F_400_HZ 13'h0190
`define ETC_F_300_HZ 13'h012c
`define ETC_RED_0_DB 4'h0
`define ETC_RED_1_DB 4'h6
`define ETC_RED_2_DB 4'h9
`define ETC_RED_34_DB 4'hc

`endif

//--- design/etc_pkg.sv
// Purpose: types shared by the tonality classifier and its bench
// Assumes: energies arrive as signed Q8.8 dB
// Notes: numbers live in etc_regs.svh
package etc_pkg;

   typedef logic [2:0] etc_cat_t;

   // frame sequencer states
   typedef enum logic [1:0] {
      ETC_ST_IDLE = 2'b00,
      ETC_ST_ACC = 2'b01,
      ETC_ST_DECIDE = 2'b10
   } etc_state_e;

   // per-frame input from the spectral analysis
   typedef struct packed {
      logic signed [15:0] energy;
      logic erasure;
      logic voice_active;
      logic generic_audio_coding;
   } etc_frame_s;

   // per-frame instruction to the noise reducer
   typedef struct packed {
      etc_cat_t cat;
      logic bypass;
      logic [3:0] max_red_db;
      logic [12:0] start_hz;
      logic [12:0] stop_hz;
   } etc_tuning_s;

endpackage : etc_pkg

//--- design/etc_classifier.sv
// Purpose: per-frame excitation tonality classifier steering an inter-tone noise reducer
// Assumes: frame_strobe_i is a one-cycle pulse, frames at least 20 cycles apart
// Notes: strobes arriving while a frame is still being evaluated are ignored
// Behaviour
// - mean of last forty frame-to-frame energy differences is formed each frame.
// - deviation of last fifteen differences from that mean, scaled by 0.77.
// - deviation against four adaptive thresholds picks one of five categories.
// - category sets start frequency and allowed reduction; all end at 6400 Hz.
// - category 0 tells the noise reducer to leave the frame unmodified.
// - category 1 when below threshold 1 and previous category at least 0.
// - category 2 when below threshold 2 and previous category at least 1.
// - category 3 when below threshold 3 and previous category at least 2.
// - category 4 when below threshold 4 and previous category at least 3.
// - more than thirty consecutive category 3 or 4 frames raise all thresholds.
// - more than thirty consecutive category 0 frames lower all thresholds.
// - every threshold stays clamped between fixed minimum and maximum.
// - erasure resets thresholds to minimum and forces category 0 for three frames.
// - silence or previous frame not generic audio forces category 0.
//
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "etc_regs.svh"

module etc_classifier
   import etc_pkg::*;
#(
   parameter int HIST_FRAMES = `ETC_HIST_FRAMES,
   parameter int DEV_FRAMES = `ETC_DEV_FRAMES,
   parameter int RUN_LIMIT = `ETC_RUN_LIMIT,
   parameter logic [3:0][31:0] THR_INIT = `ETC_THR_INIT,
   parameter logic [3:0][31:0] THR_MIN = `ETC_THR_MIN,
   parameter logic [3:0][31:0] THR_MAX = `ETC_THR_MAX,
   parameter logic [31:0] THR_STEP = `ETC_THR_STEP
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic frame_strobe_i,
   input wire etc_frame_s frame_i,
   output etc_tuning_s tuning_o,
   output logic tuning_valid_o
);

   localparam int PW = $clog2(HIST_FRAMES);
   localparam int KW = $clog2(DEV_FRAMES);
   localparam logic [16:0] RECIP_Q16 = 17'((65536 + HIST_FRAMES / 2) / HIST_FRAMES);
   localparam int P2_Q16 = (`ETC_DEV_SCALE_X100 * `ETC_DEV_SCALE_X100 * 65536) / 10000;
   localparam logic [15:0] GAIN_Q16 = 16'(P2_Q16 / DEV_FRAMES);

   // the evaluation walks back through the history, so it must be deep enough
   if (HIST_FRAMES < DEV_FRAMES || DEV_FRAMES < 2 || !(RUN_LIMIT inside {[1:254]})) begin : g_bad
      $error("etc_classifier: unsupported frame counts");
   end

   // step a history pointer one frame back, wrapping
   function automatic logic [PW-1:0] ptr_back(input logic [PW-1:0] p);
      return (p == '0) ? PW'(HIST_FRAMES - 1) : p - PW'(1);
   endfunction : ptr_back

   // keep a threshold inside its limits
   function automatic logic [31:0] clamp(input logic [32:0] v, input logic [31:0] lo,
                                         input logic [31:0] hi);
      if (v > {1'b0, hi}) return hi;
      if (v < {1'b0, lo}) return lo;
      return v[31:0];
   endfunction : clamp

   // tuning handed to the noise reducer for one category
   function automatic etc_tuning_s tune(input etc_cat_t c);
      etc_tuning_s t;
      t.cat = c;
      t.bypass = 1'b0;
      t.stop_hz = `ETC_F_STOP_HZ;
      t.start_hz = `ETC_F_510_HZ;
      t.max_red_db = `ETC_RED_34_DB;
      case (c)
         3'd1: t.max_red_db = `ETC_RED_1_DB;
         3'd2: t.max_red_db = `ETC_RED_2_DB;
         3'd3: t.start_hz = `ETC_F_400_HZ;
         3'd4: t.start_hz = `ETC_F_300_HZ;
         default: begin
            t.bypass = 1'b1;
            t.max_red_db = `ETC_RED_0_DB;
         end
      endcase
      return t;
   endfunction : tune

   etc_state_e state_reg;
   logic signed [16:0] hist_reg [HIST_FRAMES];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [KW-1:0] k_reg;
   logic signed [22:0] sum_reg;
   logic signed [15:0] prev_energy_reg;
   logic [39:0] sq_acc_reg;
   logic [31:0] dev_reg;
   logic [3:0][31:0] thr_reg;
   logic [7:0] run_tonal_reg;
   logic [7:0] run_plain_reg;
   logic [1:0] hold_reg;
   logic force_reg;
   logic gac_last_reg;
   logic en_reg;
   etc_cat_t cat_reg;
   logic [31:0] frames_reg;

   logic push;
   logic erase;
   logic signed [16:0] diff_now;
   logic signed [40:0] mean_full;
   logic signed [17:0] dev_now;
   logic [55:0] var_full;
   logic [31:0] var_now;
   etc_cat_t cat_next;
   logic raise;
   logic lower;

   assign erase = frame_strobe_i && frame_i.erasure && state_reg == ETC_ST_IDLE;
   assign push = frame_strobe_i && !frame_i.erasure && state_reg == ETC_ST_IDLE;
   assign diff_now = 17'(frame_i.energy) - 17'(prev_energy_reg);
   // mean of forty differences by reciprocal multiply
   assign mean_full = sum_reg * $signed({1'b0, RECIP_Q16});
   assign dev_now = 18'(hist_reg[rd_ptr_reg]) - 18'(mean_full >>> 16);
   // scaled deviation, kept squared so no root is needed
   assign var_full = sq_acc_reg * GAIN_Q16;
   assign var_now = (var_full[55:48] != '0) ? 32'hffff_ffff : var_full[47:16];

   always_comb begin
      cat_next = 3'd0;
      if (var_now < thr_reg[3] && cat_reg >= 3'd3) begin
         cat_next = 3'd4;
      end else if (var_now < thr_reg[2] && cat_reg >= 3'd2) begin
         cat_next = 3'd3;
      end else if (var_now < thr_reg[1] && cat_reg >= 3'd1) begin
         cat_next = 3'd2;
      end else if (var_now < thr_reg[0]) begin
         cat_next = 3'd1;
      end
      if (hold_reg != 2'd0 || force_reg || !en_reg) begin
         cat_next = 3'd0;
      end
   end

   // a run beyond the limit moves the thresholds
   assign raise = state_reg == ETC_ST_DECIDE && cat_next >= 3'd3 && run_tonal_reg == 8'(RUN_LIMIT);
   assign lower = state_reg == ETC_ST_DECIDE && cat_next == 3'd0 && run_plain_reg == 8'(RUN_LIMIT);

   // frame sequencer: fifteen accumulate cycles, then one decision cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ETC_ST_IDLE;
         k_reg <= '0;
      end else begin
         case (state_reg)
            ETC_ST_IDLE: begin
               k_reg <= '0;
               if (push) begin
                  state_reg <= ETC_ST_ACC;
               end
            end
            ETC_ST_ACC: begin
               k_reg <= k_reg + KW'(1);
               if (k_reg == KW'(DEV_FRAMES - 1)) begin
                  state_reg <= ETC_ST_DECIDE;
               end
            end
            ETC_ST_DECIDE: state_reg <= ETC_ST_IDLE;
            default: state_reg <= ETC_ST_IDLE;
         endcase
      end
   end

   // difference history and running sum; a lost frame adds no difference
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < HIST_FRAMES; i++) begin
            hist_reg[i] <= '0;
         end
         wr_ptr_reg <= '0;
         sum_reg <= '0;
         prev_energy_reg <= '0;
      end else if (push) begin
         hist_reg[wr_ptr_reg] <= diff_now;
         wr_ptr_reg <= (wr_ptr_reg == PW'(HIST_FRAMES - 1)) ? '0 : wr_ptr_reg + PW'(1);
         sum_reg <= sum_reg + 23'(diff_now) - 23'(hist_reg[wr_ptr_reg]);
         prev_energy_reg <= frame_i.energy;
      end
   end

   // squared deviations of the fifteen newest differences
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_ptr_reg <= '0;
         sq_acc_reg <= '0;
      end else if (push) begin
         rd_ptr_reg <= wr_ptr_reg;
         sq_acc_reg <= '0;
      end else if (state_reg == ETC_ST_ACC) begin
         rd_ptr_reg <= ptr_back(rd_ptr_reg);
         sq_acc_reg <= sq_acc_reg + 40'(dev_now * dev_now);
      end
   end

   // latch the frame flags; the generic audio flag is used one frame late
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         force_reg <= 1'b1;
         gac_last_reg <= 1'b0;
      end else if (push || erase) begin
         // silence or non generic previous frame
         force_reg <= !frame_i.voice_active || !gac_last_reg;
         gac_last_reg <= frame_i.generic_audio_coding;
      end
   end

   // erasure hold counts the lost frame plus two more
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_reg <= '0;
      end else if (erase) begin
         hold_reg <= 2'(`ETC_ERASE_FRAMES - 1);
      end else if (state_reg == ETC_ST_DECIDE && hold_reg != 2'd0) begin
         hold_reg <= hold_reg - 2'd1;
      end
   end

   // run counters restart after each threshold move
   always_ff @(posedge clk_i) begin
      if (rst_i || erase) begin
         run_tonal_reg <= '0;
         run_plain_reg <= '0;
      end else if (state_reg == ETC_ST_DECIDE) begin
         // count category 3 or 4 frames
         run_tonal_reg <= (cat_next >= 3'd3 && !raise) ? run_tonal_reg + 8'd1 : '0;
         run_plain_reg <= (cat_next == 3'd0 && !lower) ? run_plain_reg + 8'd1 : '0;
      end
   end

   // floating thresholds
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         thr_reg <= THR_INIT;
      end else if (erase) begin
         thr_reg <= THR_MIN;
      end else if (raise || lower) begin
         for (int i = 0; i < 4; i++) begin
            thr_reg[i] <= clamp(raise ? {1'b0, thr_reg[i]} + {1'b0, THR_STEP}
               : {1'b0, thr_reg[i]} - {1'b0, THR_STEP}, THR_MIN[i], THR_MAX[i]);
         end
      end
   end

   // category result and tuning output
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cat_reg <= 3'd0;
         dev_reg <= '0;
         tuning_o <= tune(3'd0);
         tuning_valid_o <= 1'b0;
         frames_reg <= '0;
      end else begin
         tuning_valid_o <= 1'b0;
         // lost frame answers at once with category 0
         if (erase) begin
            cat_reg <= 3'd0;
            tuning_o <= tune(3'd0);
            tuning_valid_o <= 1'b1;
            frames_reg <= frames_reg + 32'd1;
         end else if (state_reg == ETC_ST_DECIDE) begin
            cat_reg <= cat_next;
            dev_reg <= var_now;
            tuning_o <= tune(cat_next);
            tuning_valid_o <= 1'b1;
            frames_reg <= frames_reg + 32'd1;
         end
      end
   end

   // wishbone slave: acknowledge one cycle after the request, drop ack for one cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
         en_reg <= `ETC_CTRL_RST;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= '0;
         if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            if (wb_we_i && wb_adr_i == `ETC_ADR_CTRL && wb_sel_i[0]) begin
               en_reg <= wb_dat_i[`ETC_CTRL_EN_BIT];
            end
            if (!wb_we_i) begin
               // unmapped words read as zero
               case (wb_adr_i)
                  `ETC_ADR_CTRL: wb_dat_o[`ETC_CTRL_EN_BIT] <= en_reg;
                  `ETC_ADR_STATUS: begin
                     wb_dat_o[`ETC_ST_CAT_LSB +: 3] <= cat_reg;
                     wb_dat_o[`ETC_ST_HOLD_LSB +: 2] <= hold_reg;
                     wb_dat_o[`ETC_ST_TONAL_LSB +: 8] <= run_tonal_reg;
                     wb_dat_o[`ETC_ST_PLAIN_LSB +: 8] <= run_plain_reg;
                  end
                  `ETC_ADR_DEV: wb_dat_o <= dev_reg;
                  `ETC_ADR_THR1: wb_dat_o <= thr_reg[0];
                  `ETC_ADR_THR2: wb_dat_o <= thr_reg[1];
                  `ETC_ADR_THR3: wb_dat_o <= thr_reg[2];
                  `ETC_ADR_THR4: wb_dat_o <= thr_reg[3];
                  `ETC_ADR_FRAMES: wb_dat_o <= frames_reg;
                  default: wb_dat_o <= '0;
               endcase
            end
         end
      end
   end

endmodule : etc_classifier

//--- verif/etc_classifier_checker.sv
// Purpose: protocol and classification checks on the tonality classifier ports
// Assumes: frames are offered only while the classifier is idle
// Notes: latencies follow the default deviation window of fifteen frames
`timescale 1ns/1ps
`include "etc_regs.svh"
module etc_classifier_checker
   import etc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic frame_strobe_i,
   input wire etc_frame_s frame_i,
   input wire etc_tuning_s tuning_o,
   input wire logic tuning_valid_o
);
   etc_cat_t last_cat_reg;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // last published category, the base for the one-step climb limit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_cat_reg <= 3'h0;
      end else if (tuning_valid_o) begin
         last_cat_reg <= tuning_o.cat;
      end
   end
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_erase; frame_strobe_i && frame_i.erasure; endsequence
   sequence s_frame; frame_strobe_i && !frame_i.erasure; endsequence
   sequence s_cat(logic [2:0] c); tuning_valid_o && tuning_o.cat == c; endsequence
   property p_ack; s_req |=> wb_ack_o ##1 !wb_ack_o; endproperty
   property p_dat; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
   property p_lat; s_frame |=> (!tuning_valid_o) [*8] ##9 tuning_valid_o; endproperty
   property p_erase; s_erase |=> s_cat(3'h0); endproperty
   property p_silence; s_frame and !frame_i.voice_active |-> ##17 s_cat(3'h0); endproperty
   property p_bypass;
      tuning_valid_o |-> tuning_o.bypass == (tuning_o.cat == 3'h0)
         && tuning_o.stop_hz == `ETC_F_STOP_HZ;
   endproperty
   property p_low;
      s_cat(3'h1) or s_cat(3'h2) |-> tuning_o.start_hz == `ETC_F_510_HZ
         && tuning_o.max_red_db == (tuning_o.cat == 3'h1 ? `ETC_RED_1_DB : `ETC_RED_2_DB);
   endproperty
   property p_high;
      tuning_valid_o && tuning_o.cat >= 3'h3 |-> tuning_o.max_red_db == `ETC_RED_34_DB
         && tuning_o.start_hz == (tuning_o.cat == 3'h3 ? `ETC_F_400_HZ : `ETC_F_300_HZ);
   endproperty
   property p_climb;
      tuning_valid_o |-> tuning_o.cat <= 3'h4 && tuning_o.cat <= last_cat_reg + 3'h1;
   endproperty
   property p_hold; !tuning_valid_o |-> $stable(tuning_o); endproperty
   a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
   a_dat: assert property (p_dat) else $error("read data outside ack");
   a_lat: assert property (p_lat) else $error("frame result timing wrong");
   a_erase: assert property (p_erase) else $error("erasure not category 0");
   a_silence: assert property (p_silence) else $error("silence not category 0");
   a_bypass: assert property (p_bypass) else $error("bypass or stop wrong");
   a_low: assert property (p_low) else $error("category 1 or 2 tuning wrong");
   a_high: assert property (p_high) else $error("category 3 or 4 tuning wrong");
   a_climb: assert property (p_climb) else $error("category jumped");
   a_hold: assert property (p_hold) else $error("tuning moved without valid");
endmodule : etc_classifier_checker

bind etc_classifier etc_classifier_checker chk_inst (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .frame_strobe_i(frame_strobe_i), .frame_i(frame_i), .tuning_o(tuning_o),
   .tuning_valid_o(tuning_valid_o));

//--- verif/etc_frame_source.sv
// Purpose: stand-in for the upstream spectral analysis feeding frame records
// Assumes: send_i is a one-cycle request from the bench
// Notes: the record toggles outside the strobe so stale data never looks valid
`timescale 1ns/1ps
module etc_frame_source
   import etc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic send_i,
   input wire etc_frame_s frame_i,
   output logic frame_strobe_o,
   output etc_frame_s frame_o
);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frame_strobe_o <= 1'b0;
         frame_o <= '0;
      end else if (send_i) begin
         frame_strobe_o <= 1'b1;
         frame_o <= frame_i;
      end else begin
         frame_strobe_o <= 1'b0;
         frame_o <= ~frame_o;
      end
   end
endmodule : etc_frame_source

//--- verif/test_etc_classifier.sv
// Purpose: register and frame sequences for the tonality classifier
// Assumes: run limit shortened to 3 so threshold steps come quickly
// Notes: zero energy keeps the deviation at 0, a large swing pushes it past all limits
`timescale 1ns/1ps
`include "etc_regs.svh"
module test_etc_classifier
   import etc_pkg::*;
;
   localparam logic [3:0][31:0] TMAX = `ETC_THR_MAX;
   localparam logic [3:0][31:0] TMIN = `ETC_THR_MIN;
   logic clk_i, rst_i, req, wr, ack, send, strobe, tvalid;
   logic [7:0] adr;
   logic [31:0] wdat, rdat;
   etc_frame_s frm_req, frm;
   etc_tuning_s tuning;
   logic [3:0][31:0] thr_exp;
   int error_cnt = 0;
   int cmp_count = 0;

   etc_classifier #(.RUN_LIMIT(3)) etc_classifier_inst (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(wr), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .frame_strobe_i(strobe),
      .frame_i(frm), .tuning_o(tuning), .tuning_valid_o(tvalid));
   etc_frame_source etc_frame_source_inst (.clk_i(clk_i), .rst_i(rst_i), .send_i(send),
      .frame_i(frm_req), .frame_strobe_o(strobe), .frame_o(frm));

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL at %0t: saw %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one classic cycle, held until ack is sampled high
   task automatic wb_io(input logic we, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] rd);
      @(posedge clk_i);
      req <= 1'b1;
      wr <= we;
      adr <= a;
      wdat <= wd;
      // no own limit: a slave that never answers is caught by the watchdog
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rd = rdat;
      req <= 1'b0;
   endtask : wb_io

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      wb_io(1'b0, a, 32'h0, rd);
      chk(rd, exp);
   endtask : rd_chk

   task automatic thr_all;
      for (int i = 0; i < 4; i++) rd_chk(`ETC_ADR_THR1 + 8'(4 * i), thr_exp[i]);
   endtask : thr_all

   // one step on every threshold, clamped at its own limit
   task automatic move(input logic up);
      for (int i = 0; i < 4; i++) begin
         if (up) thr_exp[i] = (thr_exp[i] + `ETC_THR_STEP > TMAX[i]) ? TMAX[i] :
            thr_exp[i] + `ETC_THR_STEP;
         else thr_exp[i] = (thr_exp[i] < TMIN[i] + `ETC_THR_STEP) ? TMIN[i] :
            thr_exp[i] - `ETC_THR_STEP;
      end
   endtask : move

   // frames spaced well apart, since strobes during evaluation are dropped
   task automatic frame(input logic [15:0] e, input logic er, va, ga, input logic [2:0] c);
      int n;
      n = 0;
      repeat (20) @(posedge clk_i);
      frm_req <= {e, er, va, ga};
      send <= 1'b1;
      @(posedge clk_i);
      send <= 1'b0;
      do begin
         @(posedge clk_i);
         n++;
      end while (tvalid !== 1'b1 && n < 40);
      // a missing result must not pass on a stale category
      if (n >= 40) begin
         error_cnt++;
         $display("FAIL at %0t: no frame result", $time);
      end
      chk(32'(tuning.cat), 32'(c));
   endtask : frame

   task automatic end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test

   initial begin
      logic [31:0] rd;
      rst_i = 1'b1;
      req = 1'b0;
      wr = 1'b0;
      adr = 8'h00;
      wdat = 32'h0;
      send = 1'b0;
      frm_req = '0;
      thr_exp = `ETC_THR_INIT;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(`ETC_ADR_CTRL, 32'h1);
      rd_chk(`ETC_ADR_STATUS, 32'h0);
      rd_chk(`ETC_ADR_DEV, 32'h0);
      rd_chk(8'h20, 32'h0);
      wb_io(1'b1, `ETC_ADR_THR1, 32'h0000_0123, rd);
      thr_all();
      frame(16'h0, 1'b0, 1'b1, 1'b1, 3'h0);
      // climb one category per frame, then a long tonal run
      for (int j = 1; j < 44; j++) begin
         frame(16'h0, 1'b0, 1'b1, 1'b1, (j < 4) ? 3'(j) : 3'h4);
         if (j > 2 && (j - 2) % 4 == 0) move(1'b1);
      end
      thr_all();
      for (int j = 0; j < 4; j++) frame(16'h0, 1'b0, 1'b0, 1'b1, 3'h0);
      move(1'b0);
      thr_all();
      frame(16'h0, 1'b0, 1'b1, 1'b0, 3'h1);
      frame(16'h0, 1'b0, 1'b1, 1'b1, 3'h0);
      wb_io(1'b1, `ETC_ADR_CTRL, 32'h0, rd);
      frame(16'h0, 1'b0, 1'b1, 1'b1, 3'h0);
      wb_io(1'b1, `ETC_ADR_CTRL, 32'h1, rd);
      rd_chk(`ETC_ADR_CTRL, 32'h1);
      frame(16'h0, 1'b1, 1'b1, 1'b1, 3'h0);
      thr_exp = `ETC_THR_MIN;
      thr_all();
      rd_chk(`ETC_ADR_STATUS, 32'h0000_0020);
      frame(16'h0, 1'b0, 1'b1, 1'b1, 3'h0);
      frame(16'h0, 1'b0, 1'b1, 1'b1, 3'h0);
      frame(16'h0, 1'b0, 1'b1, 1'b1, 3'h1);
      frame(16'h4000, 1'b0, 1'b1, 1'b1, 3'h0);
      rd_chk(`ETC_ADR_FRAMES, 32'h0000_0038);
      end_of_test();
   end

   initial begin
      repeat (10000) @(posedge clk_i);
      error_cnt++;
      $display("FAIL at %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule : test_etc_classifier
